// ### dv/auxio_ext_model.sv
/*
 Model of the external equipment wired to the auxiliary line.
 Assumes the bench sets the level that the equipment wants to drive.
*/
`timescale 1ns/100ps
module auxio_ext_model (
   // Bench side
   input wire logic drv_level,
   // Line side
   input wire logic dut_out,
   input wire logic dut_oe_n,
   output logic line
);
   // Equipment lets go while the block drives, so no contention
   assign line = dut_oe_n ? drv_level : dut_out;
endmodule : auxio_ext_model

// ### dv/auxio_tb.sv
/*
 Self-checking bench for the auxiliary line control block.
 Assumes the block and the external equipment model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb
   import auxio_pkg::*;
;
   logic clk_sys = 0, rst_n = 0, lvl = 0, dir = 0, inv = 0, line, out, oe_n;
   logic [2:0] act = 3'h0, cond = 3'h0;
   logic [3:0] st = 4'h0;
   wire [4:0] cmd;
   int bad_count = 0, num_checks = 0, cyc = 0;
   auxio_ext_model ext_u (.drv_level(lvl), .dut_out(out), .dut_oe_n(oe_n), .line(line));
   auxio_line_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .aux_io_line_in(line),
      .aux_io_line_out(out), .aux_io_line_oe_n(oe_n), .dir_is_output(dir), .invert(inv),
      .in_action_sel(act), .out_cond_sel(cond), .stat_moving(st[3]), .stat_alarm(st[2]),
      .stat_powered(st[1]), .stat_found(st[0]), .stop_command(cmd[4]),
      .power_off_command(cmd[3]), .movr_command(cmd[2]), .home_command(cmd[1]),
      .alarm_enter(cmd[0]));
   initial forever #25 clk_sys = ~clk_sys;
   // ----------------------------------------
   // Expected values
   // ----------------------------------------
   function automatic logic [4:0] exp_cmd(input logic [2:0] s);
      case (s)
         AUXIO_ACT_STOP: return 5'h10;
         AUXIO_ACT_PWOFF: return 5'h08;
         AUXIO_ACT_MOVR: return 5'h04;
         AUXIO_ACT_HOME: return 5'h02;
         AUXIO_ACT_ALARM: return 5'h01;
         default: return 5'h00;
      endcase
   endfunction : exp_cmd
   function automatic logic exp_out(input logic [2:0] c, input logic [3:0] s, input logic i);
      case (c)
         AUXIO_OUT_ON: return ~i;
         AUXIO_OUT_MOVING: return s[3] ^ i;
         AUXIO_OUT_ALARM: return s[2] ^ i;
         AUXIO_OUT_POWERED: return s[1] ^ i;
         AUXIO_OUT_FOUND: return s[0] ^ i;
         default: return i;
      endcase
   endfunction : exp_out
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic edge_chk(input logic [2:0] s, input logic l, input logic [4:0] e);
      @(posedge clk_sys);
      act <= s;
      lvl <= l;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("command pulse", e, cmd)
      @(posedge clk_sys);
      #1;
      `CHK("command end", 5'h00, cmd)
   endtask : edge_chk
   task automatic out_chk(input logic [2:0] c, input logic [3:0] s);
      @(posedge clk_sys);
      cond <= c;
      st <= s;
      lvl <= ~lvl;
      @(posedge clk_sys);
      #1;
      `CHK("line out", exp_out(c, s, inv), line)
      `CHK("drive enable", 1'b0, oe_n)
      `CHK("no command", 5'h00, cmd)
   endtask : out_chk
   task automatic print_verdict;
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("input release", 1'b1, oe_n)
      for (int i = 0; i < 8; i++) begin
         edge_chk(i[2:0], 1'b1, exp_cmd(i[2:0]));
         edge_chk(i[2:0], 1'b0, 5'h00);
      end
      @(posedge clk_sys);
      inv <= 1'b1;
      edge_chk(AUXIO_ACT_STOP, 1'b1, 5'h00);
      edge_chk(AUXIO_ACT_HOME, 1'b0, 5'h02);
      @(posedge clk_sys);
      dir <= 1'b1;
      for (int v = 1; v >= 0; v--) begin
         @(posedge clk_sys);
         inv <= v[0];
         for (int i = 0; i < 8; i++) begin
            out_chk(i[2:0], 4'hA);
            out_chk(i[2:0], 4'h5);
         end
      end
      @(posedge clk_sys);
      dir <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK("drive release", 1'b1, oe_n)
      // Mid-run reset with the line held high: no action may follow
      @(posedge clk_sys);
      act <= AUXIO_ACT_STOP;
      lvl <= 1'b1;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) begin
         @(posedge clk_sys);
         #1;
         `CHK("quiet after reset", 5'h00, cmd)
      end
      edge_chk(AUXIO_ACT_STOP, 1'b0, 5'h00);
      edge_chk(AUXIO_ACT_STOP, 1'b1, 5'h10);
      print_verdict();
   end
endmodule : tb

// ### logic/auxio_line_ctrl.sv
/*
 Control logic for one auxiliary general purpose line of a motor controller.
 Assumes the line pin is resolved by the surroundings from out/oe_n, that the
 status inputs come from logic on clk_sys, and the action pulses are consumed
 by the motion core in the cycle they appear.
*/
`timescale 1ns/100ps

module auxio_line_ctrl
   import auxio_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Line pin
   input wire logic aux_io_line_in,
   output logic aux_io_line_out,
   output logic aux_io_line_oe_n,
   // Configuration
   input wire logic dir_is_output,
   input wire logic invert,
   input wire logic [AUXIO_ACT_W-1:0] in_action_sel,
   input wire logic [AUXIO_OUT_W-1:0] out_cond_sel,
   // Controller status
   input wire logic stat_moving,
   input wire logic stat_alarm,
   input wire logic stat_powered,
   input wire logic stat_found,
   // Action requests, one-cycle pulses
   output logic stop_command,
   output logic power_off_command,
   output logic movr_command,
   output logic home_command,
   output logic alarm_enter
);

   // ----------------------------------------
   // Start-up qualifier
   // ----------------------------------------
   // A level held across reset is no edge: wait until the
   // edge register holds a real pin sample
   logic warm1_q, warm2_q, warm3_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         warm1_q <= 1'b0;
         warm2_q <= 1'b0;
         warm3_q <= 1'b0;
      end else begin
         warm1_q <= 1'b1;
         warm2_q <= warm1_q;
         warm3_q <= warm2_q;
      end
   end

   wire primed_w = warm3_q;

   // ----------------------------------------
   // Input synchroniser and edge detect
   // ----------------------------------------
   logic sync1_q, sync2_q, prev_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= AUXIO_SYNC_RST;
         sync2_q <= AUXIO_SYNC_RST;
         prev_q <= AUXIO_SYNC_RST;
      end else begin
         sync1_q <= aux_io_line_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   wire rise_w = sync2_q & ~prev_q;
   wire fall_w = ~sync2_q & prev_q;
   wire edge_w = invert ? fall_w : rise_w;
   // Own driven level seen back on the pin must not fire actions
   wire fire_w = edge_w & ~dir_is_output & primed_w;

   // ----------------------------------------
   // Action request registers
   // ----------------------------------------
   logic stop_q, pwoff_q, movr_q, home_q, alarm_q;
   wire stop_d = fire_w & (in_action_sel == AUXIO_ACT_STOP);
   wire pwoff_d = fire_w & (in_action_sel == AUXIO_ACT_PWOFF);
   wire movr_d = fire_w & (in_action_sel == AUXIO_ACT_MOVR);
   wire home_d = fire_w & (in_action_sel == AUXIO_ACT_HOME);
   wire alarm_d = fire_w & (in_action_sel == AUXIO_ACT_ALARM);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stop_q <= 1'b0;
         pwoff_q <= 1'b0;
         movr_q <= 1'b0;
         home_q <= 1'b0;
         alarm_q <= 1'b0;
      end else begin
         stop_q <= stop_d;
         pwoff_q <= pwoff_d;
         movr_q <= movr_d;
         home_q <= home_d;
         alarm_q <= alarm_d;
      end
   end

   assign stop_command = stop_q;
   assign power_off_command = pwoff_q;
   assign movr_command = movr_q;
   assign home_command = home_q;
   assign alarm_enter = alarm_q;

   // ----------------------------------------
   // Output condition
   // ----------------------------------------
   logic cond_w;
   always_comb begin
      case (out_cond_sel)
         AUXIO_OUT_OFF: cond_w = 1'b0;
         AUXIO_OUT_ON: cond_w = 1'b1;
         AUXIO_OUT_MOVING: cond_w = stat_moving;
         AUXIO_OUT_ALARM: cond_w = stat_alarm;
         AUXIO_OUT_POWERED: cond_w = stat_powered;
         AUXIO_OUT_FOUND: cond_w = stat_found;
         default: cond_w = 1'b0;
      endcase
   end

   logic out_q, oe_n_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         // Inversion makes the low level the active one
         out_q <= cond_w ^ invert;
         oe_n_q <= ~dir_is_output;
      end
   end

   assign aux_io_line_out = out_q;
   assign aux_io_line_oe_n = oe_n_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   dir_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 (aux_io_line_oe_n == !$past(dir_is_output)))
      else $error("line enable does not follow direction");

   rise_fires_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (primed_w && !dir_is_output && !invert && sync2_q && !prev_q
      && in_action_sel == AUXIO_ACT_STOP) |=> stop_command)
      else $error("rising edge did not fire stop");

   fall_fires_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (primed_w && !dir_is_output && invert && !sync2_q && prev_q
      && in_action_sel == AUXIO_ACT_HOME) |=> home_command)
      else $error("falling edge did not fire home");

   wrong_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (invert && sync2_q && !prev_q) |=> !(stop_command || home_command || movr_command
      || power_off_command || alarm_enter))
      else $error("ignored edge fired an action");

   pwoff_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      power_off_command |-> $past(in_action_sel) == AUXIO_ACT_PWOFF && !$past(dir_is_output))
      else $error("power off without its selection");

   single_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (stop_command || movr_command || alarm_enter) |=> !(stop_command || movr_command
      || alarm_enter))
      else $error("action request longer than one cycle");

   out_move_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (out_cond_sel == AUXIO_OUT_MOVING) |=> aux_io_line_out == ($past(stat_moving)
      ^ $past(invert)))
      else $error("output does not follow moving state");

   out_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (out_cond_sel == AUXIO_OUT_ON && !invert) [*2] |-> aux_io_line_out)
      else $error("always-on output not active");

   start_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !primed_w |=> !(stop_command || home_command || movr_command
      || power_off_command || alarm_enter))
      else $error("action fired before first pin sample");

   out_mode_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dir_is_output |=> !(stop_command || home_command || movr_command
      || power_off_command || alarm_enter))
      else $error("action fired in output mode");

   one_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $onehot0({stop_command, power_off_command, movr_command, home_command, alarm_enter}))
      else $error("more than one action at once");

   stop_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stop_command |-> $past(in_action_sel) == AUXIO_ACT_STOP && !$past(dir_is_output))
      else $error("stop without its selection");

   movr_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      movr_command |-> $past(in_action_sel) == AUXIO_ACT_MOVR && !$past(dir_is_output))
      else $error("relative move without its selection");

   home_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      home_command |-> $past(in_action_sel) == AUXIO_ACT_HOME && !$past(dir_is_output))
      else $error("home without its selection");

   alarm_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      alarm_enter |-> $past(in_action_sel) == AUXIO_ACT_ALARM && !$past(dir_is_output))
      else $error("alarm entry without its selection");

   single_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (home_command || power_off_command) |=> !(home_command || power_off_command))
      else $error("home or power off longer than one cycle");

   out_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (out_cond_sel == AUXIO_OUT_OFF) |=> aux_io_line_out == $past(invert))
      else $error("always-off output not inactive");

   out_alarm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (out_cond_sel == AUXIO_OUT_ALARM) |=> aux_io_line_out == ($past(stat_alarm)
      ^ $past(invert)))
      else $error("output does not follow alarm state");

   out_power_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (out_cond_sel == AUXIO_OUT_POWERED) |=> aux_io_line_out == ($past(stat_powered)
      ^ $past(invert)))
      else $error("output does not follow winding power");

   out_found_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (out_cond_sel == AUXIO_OUT_FOUND) |=> aux_io_line_out == ($past(stat_found)
      ^ $past(invert)))
      else $error("output does not follow motor found");

endmodule : auxio_line_ctrl

// ### shared/auxio_pkg.sv
/*
 Shared constants for the auxiliary line control block: input action codes,
 output condition codes and synchroniser reset level.
 Assumes the user of the block drives the mode selects from static configuration.
*/
package auxio_pkg;

   // ----------------------------------------
   // Input action selection
   // ----------------------------------------
   localparam int AUXIO_ACT_W = 3;
   localparam logic [2:0] AUXIO_ACT_NONE = 3'h0;
   localparam logic [2:0] AUXIO_ACT_STOP = 3'h1;
   localparam logic [2:0] AUXIO_ACT_PWOFF = 3'h2;
   localparam logic [2:0] AUXIO_ACT_MOVR = 3'h3;
   localparam logic [2:0] AUXIO_ACT_HOME = 3'h4;
   localparam logic [2:0] AUXIO_ACT_ALARM = 3'h5;

   // ----------------------------------------
   // Output condition selection
   // ----------------------------------------
   localparam int AUXIO_OUT_W = 3;
   localparam logic [2:0] AUXIO_OUT_OFF = 3'h0;
   localparam logic [2:0] AUXIO_OUT_ON = 3'h1;
   localparam logic [2:0] AUXIO_OUT_MOVING = 3'h2;
   localparam logic [2:0] AUXIO_OUT_ALARM = 3'h3;
   localparam logic [2:0] AUXIO_OUT_POWERED = 3'h4;
   localparam logic [2:0] AUXIO_OUT_FOUND = 3'h5;

   // ----------------------------------------
   // Synchroniser reset level
   // ----------------------------------------
   localparam logic AUXIO_SYNC_RST = 1'b0;

endpackage : auxio_pkg
